// file: design/bsdr_pkg.sv
package bsdr_pkg;

   // ************************************************************
   // chain geometry
   // ************************************************************
   localparam int NUM_IO       = 4;                          // bidirectional io_block count
   localparam int NUM_IN_ONLY  = 2;                          // input-only pin count
   localparam int CELLS_PER_IO = 3;                          // input, output, enable
   localparam int BSR_LEN      = NUM_IO * CELLS_PER_IO + NUM_IN_ONLY;
   localparam int CELL_CTRL    = 0;                          // nearest the serial output
   localparam int CELL_OUT     = 1;
   localparam int CELL_IN      = 2;                          // nearest the serial input
   localparam int IR_LEN       = 5;
   localparam int WORD_LEN     = 32;

   // ************************************************************
   // instruction codes
   // ************************************************************
   localparam logic [4:0] INSTR_EXTEST   = 5'h00;
   localparam logic [4:0] INSTR_SAMPLE   = 5'h01;
   localparam logic [4:0] INSTR_USER_A   = 5'h02;            // user_chain_a_instr
   localparam logic [4:0] INSTR_USER_B   = 5'h03;            // user_chain_b_instr
   localparam logic [4:0] INSTR_CFG_OUT  = 5'h04;
   localparam logic [4:0] INSTR_CFG_IN   = 5'h05;
   localparam logic [4:0] INSTR_INTEST   = 5'h07;
   localparam logic [4:0] INSTR_USERCODE = 5'h08;
   localparam logic [4:0] INSTR_IDCODE   = 5'h09;
   localparam logic [4:0] INSTR_HIGHZ    = 5'h0a;
   localparam logic [4:0] INSTR_START    = 5'h0c;
   localparam logic [4:0] INSTR_BYPASS   = 5'h1f;
   localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;             // fixed low bits of ir capture

   // ************************************************************
   // identification word fields (all values arbitrary)
   // ************************************************************
   localparam logic [3:0]  ID_REVISION = 4'h1;               // arbitrary
   localparam logic [6:0]  ID_FAMILY   = 7'h2a;              // arbitrary
   localparam logic [8:0]  ID_SIZE     = 9'h015;             // arbitrary
   localparam logic [10:0] ID_MAKER    = 11'h35a;            // arbitrary
   localparam logic        ID_LSB      = 1'h1;

   // ************************************************************
   // register map and reset values
   // ************************************************************
   localparam logic [7:0]  OFS_CTRL      = 8'h00;            // bit0 configuration done
   localparam logic [7:0]  OFS_USERCODE  = 8'h04;
   localparam logic [7:0]  OFS_READBACK  = 8'h08;
   localparam logic [7:0]  OFS_CFG_WORD  = 8'h0c;
   localparam logic [7:0]  OFS_CFG_COUNT = 8'h10;
   localparam logic [7:0]  OFS_STATUS    = 8'h14;
   localparam int          CTRL_DONE_BIT = 0;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [31:0] USERCODE_RST  = 32'h0000_0000;
   localparam logic [31:0] READBACK_RST  = 32'h0000_0000;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

   // ************************************************************
   // test port state
   // ************************************************************
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
      TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
      TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } bsdr_tap_e;

endpackage

// file: design/bsdr_top.sv
// Behaviour
// - five-bit instruction register, captures device status
// - three boundary cells per io_block
// - every io_block contributes cells, whatever configured
// - order input, output, enable; enable nearest output
// - input-only pins give one input cell
// - chain length and order fixed
// - capture loads parallel inputs together
// - shift one bit per test clock
// - update latches load in update-dr, clock low
// - bypass is one flip-flop
// - bypass cleared in update-dr
// - identification word fields at fixed positions
// - 32-bit access to configuration bus
// - 32-bit user code from configuration
// - user code valid only after configuration
// - user chains usable only after configuration
// - two select outputs for user instructions
// - separate shift clock per user chain
// - common serial data, reset, shift, update outputs
// - test port pins always dedicated
// - configuration, readback, identification opcodes fixed
// - user instruction opcodes 00010 and 00011
// - user instructions blocked before configuration
module bsdr_top
   import bsdr_pkg::*;
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // register bus
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   // test port pins
   input  wire logic                   tck,
   input  wire logic                   tms,
   input  wire logic                   tdi,
   output logic                        tdo,
   output logic                        tdo_oe,
   // bidirectional io_block pins and core side
   input  wire logic [NUM_IO-1:0]      io_pad_in,
   output logic      [NUM_IO-1:0]      io_pad_out,
   output logic      [NUM_IO-1:0]      io_pad_oe,
   input  wire logic [NUM_IO-1:0]      core_out,
   input  wire logic [NUM_IO-1:0]      core_oe,
   output logic      [NUM_IO-1:0]      core_in,
   // input-only pins and core side
   input  wire logic [NUM_IN_ONLY-1:0] in_pad,
   output logic      [NUM_IN_ONLY-1:0] in_core,
   // user chain port into the design
   output logic                        user_a_select,
   output logic                        user_b_select,
   output logic                        user_a_shift_clock,
   output logic                        user_b_shift_clock,
   output logic                        user_tdi,
   input  wire logic                   user_a_return_data,
   input  wire logic                   user_b_return_data,
   output logic                        tap_reset_state,
   output logic                        tap_shift_state,
   output logic                        tap_update_state
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic                   tck_s1, tck_s2, tck_s3;     // tck_s3 only for edge finding
   logic                   tms_s1, tms_s2;
   logic                   tdi_s1, tdi_s2;
   logic [NUM_IO-1:0]      io_s1, io_s2;
   logic [NUM_IN_ONLY-1:0] in_s1, in_s2;
   logic                   tck_rise, tck_fall;

   // two stages on every pin; the first stage feeds only the second
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tck_s1 <= 1'b0;
         tck_s2 <= 1'b0;
         tck_s3 <= 1'b0;
         tms_s1 <= 1'b1;            // pulled high when undriven
         tms_s2 <= 1'b1;
         tdi_s1 <= 1'b1;
         tdi_s2 <= 1'b1;
         io_s1  <= '0;
         io_s2  <= '0;
         in_s1  <= '0;
         in_s2  <= '0;
      end else begin
         tck_s1 <= tck;
         tck_s2 <= tck_s1;
         tck_s3 <= tck_s2;
         tms_s1 <= tms;
         tms_s2 <= tms_s1;
         tdi_s1 <= tdi;
         tdi_s2 <= tdi_s1;
         io_s1  <= io_pad_in;
         io_s2  <= io_s1;
         in_s1  <= in_pad;
         in_s2  <= in_s1;
      end
   end

   // tms and tdi share the tck delay, so they stay aligned to its edges
   assign tck_rise = tck_s2 & ~tck_s3;
   assign tck_fall = ~tck_s2 & tck_s3;

   // ************************************************************
   // test port state machine
   // ************************************************************
   bsdr_tap_e state, next_state;

   // pins are dedicated, no enable gates the machine
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= TAP_RESET;
      end else if (tck_rise) begin
         state <= next_state;
      end
   end

   // standard sixteen-state walk steered by tms
   always_comb begin
      unique case (state)
         TAP_RESET:    next_state = tms_s2 ? TAP_RESET    : TAP_IDLE;
         TAP_IDLE:     next_state = tms_s2 ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_DR:   next_state = tms_s2 ? TAP_SEL_IR   : TAP_CAP_DR;
         TAP_CAP_DR:   next_state = tms_s2 ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: next_state = tms_s2 ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: next_state = tms_s2 ? TAP_UPD_DR   : TAP_PAUSE_DR;
         TAP_PAUSE_DR: next_state = tms_s2 ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: next_state = tms_s2 ? TAP_UPD_DR   : TAP_SHIFT_DR;
         TAP_UPD_DR:   next_state = tms_s2 ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_IR:   next_state = tms_s2 ? TAP_RESET    : TAP_CAP_IR;
         TAP_CAP_IR:   next_state = tms_s2 ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: next_state = tms_s2 ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: next_state = tms_s2 ? TAP_UPD_IR   : TAP_PAUSE_IR;
         TAP_PAUSE_IR: next_state = tms_s2 ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: next_state = tms_s2 ? TAP_UPD_IR   : TAP_SHIFT_IR;
         TAP_UPD_IR:   next_state = tms_s2 ? TAP_SEL_DR   : TAP_IDLE;
      endcase
   end

   // ************************************************************
   // software registers
   // ************************************************************
   logic [31:0] ctrl;                 // bit0 tells the port configuration is done
   logic [31:0] usercode;             // design identification word
   logic [31:0] readback;             // word offered to readback capture
   logic [31:0] cfg_word;             // last word delivered to the configuration bus
   logic [31:0] cfg_count;            // words delivered since reset
   logic        config_done;

   assign config_done = ctrl[CTRL_DONE_BIT];

   // ************************************************************
   // instruction register and decode
   // ************************************************************
   logic [IR_LEN-1:0] ir_shift;       // shift stages
   logic [IR_LEN-1:0] ir;             // current instruction
   logic              sel_bsr, sel_word, sel_user_a, sel_user_b;

   // capture status and shift on the rise of tck, update on the low half of tck
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ir_shift <= INSTR_IDCODE;
         ir       <= INSTR_IDCODE;
      end else if (state == TAP_RESET) begin
         ir       <= INSTR_IDCODE;
      end else if (tck_rise && state == TAP_CAP_IR) begin
         ir_shift <= {2'h0, config_done, IR_CAPTURE_LOW};
      end else if (tck_rise && state == TAP_SHIFT_IR) begin
         ir_shift <= {tdi_s2, ir_shift[IR_LEN-1:1]};
      end else if (tck_fall && state == TAP_UPD_IR) begin
         ir       <= ir_shift;
      end
   end

   // which data register sits between serial input and output
   assign sel_bsr    = (ir == INSTR_EXTEST) || (ir == INSTR_SAMPLE) || (ir == INSTR_INTEST);
   assign sel_word   = (ir == INSTR_IDCODE) || (ir == INSTR_USERCODE) ||
                       (ir == INSTR_CFG_IN) || (ir == INSTR_CFG_OUT);
   // user chains act as bypass until configured
   assign sel_user_a = (ir == INSTR_USER_A) && config_done;
   assign sel_user_b = (ir == INSTR_USER_B) && config_done;

   // ************************************************************
   // bypass and 32-bit word register
   // ************************************************************
   logic                bypass_bit;   // single flip-flop
   logic [WORD_LEN-1:0] word_shift;   // shared by id, user code and config access

   // bypass shifts whenever neither boundary nor word register is selected, user chains included
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bypass_bit <= 1'b0;
      end else if (state == TAP_UPD_DR) begin
         bypass_bit <= 1'b0;
      end else if (tck_rise && !sel_bsr && !sel_word && state == TAP_CAP_DR) begin
         bypass_bit <= 1'b0;
      end else if (tck_rise && !sel_bsr && !sel_word && state == TAP_SHIFT_DR) begin
         bypass_bit <= tdi_s2;
      end
   end

   // word register: parallel load per instruction, then shift
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         word_shift <= '0;
      end else if (tck_rise && sel_word && state == TAP_CAP_DR) begin
         unique case (ir)
            INSTR_IDCODE:   word_shift <= {ID_REVISION, ID_FAMILY, ID_SIZE,
                                           ID_MAKER, ID_LSB};
            // undefined before configuration, read as zero
            INSTR_USERCODE: word_shift <= config_done ? usercode : '0;
            INSTR_CFG_OUT:  word_shift <= readback;
            default:        word_shift <= word_shift;                   // config load keeps
         endcase
      end else if (tck_rise && sel_word && state == TAP_SHIFT_DR) begin
         word_shift <= {tdi_s2, word_shift[WORD_LEN-1:1]};
      end
   end

   // each completed config word goes onto the configuration bus
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_word  <= '0;
         cfg_count <= '0;
      end else if (tck_fall && state == TAP_UPD_DR && ir == INSTR_CFG_IN) begin
         cfg_word  <= word_shift;
         cfg_count <= cfg_count + 32'h1;
      end
   end

   // ************************************************************
   // boundary register
   // ************************************************************
   logic [BSR_LEN-1:0] bsr_shift;     // fixed length, never design dependent
   logic [BSR_LEN-1:0] bsr_latch;     // update latches
   logic [BSR_LEN-1:0] bsr_capture;   // parallel inputs

   // every io_block, bonded or not, gives control, output, input
   always_comb begin
      bsr_capture = '0;
      for (int i = 0; i < NUM_IO; i++) begin
         bsr_capture[i*CELLS_PER_IO + CELL_CTRL] = core_oe[i];
         bsr_capture[i*CELLS_PER_IO + CELL_OUT]  = core_out[i];
         bsr_capture[i*CELLS_PER_IO + CELL_IN]   = io_s2[i];
      end
      // input-only pins sit nearest the serial input, one cell each
      for (int j = 0; j < NUM_IN_ONLY; j++) begin
         bsr_capture[NUM_IO*CELLS_PER_IO + j] = in_s2[j];
      end
   end

   // capture all cells at once, then shift toward bit 0
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bsr_shift <= '0;
      end else if (tck_rise && sel_bsr && state == TAP_CAP_DR) begin
         bsr_shift <= bsr_capture;
      end else if (tck_rise && sel_bsr && state == TAP_SHIFT_DR) begin
         bsr_shift <= {tdi_s2, bsr_shift[BSR_LEN-1:1]};
      end
   end

   // latches open in update-dr on the low half of tck, steady while shifting
   // the tester must preload before extest/intest, as these hold old values
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bsr_latch <= '0;
      end else if (tck_fall && state == TAP_UPD_DR && sel_bsr) begin
         bsr_latch <= bsr_shift;
      end
   end

   // ************************************************************
   // pin and core side drive
   // ************************************************************
   // registered so every output comes from a flip-flop
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         io_pad_out <= '0;
         io_pad_oe  <= '0;
         core_in    <= '0;
         in_core    <= '0;
      end else begin
         for (int i = 0; i < NUM_IO; i++) begin
            if (ir == INSTR_EXTEST) begin
               io_pad_out[i] <= bsr_latch[i*CELLS_PER_IO + CELL_OUT];
               io_pad_oe[i]  <= bsr_latch[i*CELLS_PER_IO + CELL_CTRL];
            end else begin
               io_pad_out[i] <= core_out[i];
               io_pad_oe[i]  <= core_oe[i] && (ir != INSTR_HIGHZ);
            end
            core_in[i] <= (ir == INSTR_INTEST) ? bsr_latch[i*CELLS_PER_IO + CELL_IN]
                                               : io_s2[i];
         end
         for (int j = 0; j < NUM_IN_ONLY; j++) begin
            in_core[j] <= (ir == INSTR_INTEST) ? bsr_latch[NUM_IO*CELLS_PER_IO + j]
                                               : in_s2[j];
         end
      end
   end

   // ************************************************************
   // serial output
   // ************************************************************
   logic next_tdo;

   // user return data comes from design logic on this clock
   always_comb begin
      if (state == TAP_SHIFT_IR) begin
         next_tdo = ir_shift[0];
      end else if (sel_bsr) begin
         next_tdo = bsr_shift[0];
      end else if (sel_word) begin
         next_tdo = word_shift[0];
      end else if (sel_user_a) begin
         next_tdo = user_a_return_data;
      end else if (sel_user_b) begin
         next_tdo = user_b_return_data;
      end else begin
         next_tdo = bypass_bit;
      end
   end

   // tdo moves on the falling edge and is driven only while shifting
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo    <= next_tdo;
         tdo_oe <= (state == TAP_SHIFT_IR) || (state == TAP_SHIFT_DR);
      end
   end

   // ************************************************************
   // user chain port
   // ************************************************************
   logic cap_or_shift;

   assign cap_or_shift = (state == TAP_CAP_DR) || (state == TAP_SHIFT_DR);

   // selects follow the instruction, clocks follow tck in capture/shift only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         user_a_select      <= 1'b0;
         user_b_select      <= 1'b0;
         user_a_shift_clock <= 1'b0;
         user_b_shift_clock <= 1'b0;
         user_tdi           <= 1'b1;
         tap_reset_state    <= 1'b1;
         tap_shift_state    <= 1'b0;
         tap_update_state   <= 1'b0;
      end else begin
         user_a_select      <= sel_user_a;
         user_b_select      <= sel_user_b;
         user_a_shift_clock <= sel_user_a && cap_or_shift && tck_s2;
         user_b_shift_clock <= sel_user_b && cap_or_shift && tck_s2;
         user_tdi           <= tdi_s2;
         tap_reset_state    <= (state == TAP_RESET);
         tap_shift_state    <= (state == TAP_SHIFT_DR);
         tap_update_state   <= (state == TAP_UPD_DR);
      end
   end

   // ************************************************************
   // register bus slave
   // ************************************************************
   logic       wr_pending;            // write data phase follows
   logic [7:0] wr_addr;
   logic       take;

   // zero-wait slave: always ready, always okay
   assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         wr_pending <= 1'b0;
         wr_addr    <= '0;
      end else begin
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         wr_pending <= take && hwrite;
         wr_addr    <= haddr[7:0];
      end
   end

   // writes land in the data phase; unmapped offsets are ignored
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl     <= CTRL_RST;
         usercode <= USERCODE_RST;
         readback <= READBACK_RST;
      end else if (wr_pending) begin
         unique case (wr_addr)
            OFS_CTRL:     ctrl     <= {31'h0, hwdata[CTRL_DONE_BIT]};
            OFS_USERCODE: usercode <= hwdata;
            OFS_READBACK: readback <= hwdata;
            default:      ctrl     <= ctrl;
         endcase
      end
   end

   // read data formed in the address phase, shown in the data phase
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= '0;
      end else if (take && !hwrite) begin
         unique case (haddr[7:0])
            OFS_CTRL:      hrdata <= ctrl;
            OFS_USERCODE:  hrdata <= usercode;
            OFS_READBACK:  hrdata <= readback;
            OFS_CFG_WORD:  hrdata <= cfg_word;
            OFS_CFG_COUNT: hrdata <= cfg_count;
            OFS_STATUS:    hrdata <= {23'h0, state, ir};
            default:       hrdata <= '0;
         endcase
      end else begin
         hrdata <= '0;
      end
   end

endmodule

// file: tb/bsdr_top_assertions.sv
// ************************************************************
// port-level checks
// ************************************************************
module bsdr_top_chk (
   // clock, reset and bus answer
   input wire logic clk, arst_n, hreadyout, hresp,
   // test port state flags
   input wire logic tdo_oe, tap_reset_state, tap_shift_state, tap_update_state,
   // user chain port
   input wire logic user_a_select, user_b_select, user_a_shift_clock, user_b_shift_clock
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_sel; !(user_a_select && user_b_select); endproperty
   a_sel: assert property (p_sel) else $error("both user selects high");
   property p_cka; user_a_shift_clock |-> user_a_select; endproperty
   a_cka: assert property (p_cka) else $error("chain a clock without select");
   property p_ckb; user_b_shift_clock |-> user_b_select; endproperty
   a_ckb: assert property (p_ckb) else $error("chain b clock without select");
   property p_st; !(tap_shift_state && tap_update_state); endproperty
   a_st: assert property (p_st) else $error("shift and update flags together");
   property p_rst; tap_reset_state [*2] |-> !user_a_select && !user_b_select; endproperty
   a_rst: assert property (p_rst) else $error("select held in reset state");
   property p_oe; tap_update_state |-> !tdo_oe; endproperty
   a_oe: assert property (p_oe) else $error("serial out driven outside shift");
   property p_ckst; user_a_shift_clock |-> !tap_update_state && !tap_reset_state; endproperty
   a_ckst: assert property (p_ckst) else $error("chain clock outside capture or shift");
   property p_bus; hreadyout && !hresp; endproperty
   a_bus: assert property (p_bus) else $error("bus not ready or error answer");
endmodule
bind bsdr_top bsdr_top_chk bsdr_top_chk_i (.clk, .arst_n, .hreadyout, .hresp, .tdo_oe,
   .tap_reset_state, .tap_shift_state, .tap_update_state, .user_a_select, .user_b_select,
   .user_a_shift_clock, .user_b_shift_clock);

// file: tb/bsdr_scan_host.sv
// ************************************************************
// external scan controller
// ************************************************************
module bsdr_scan_host (
   // system clock and serial return
   input  wire logic clk,
   input  wire logic tdo,
   // test port drive
   output logic      tck,
   output logic      tms,
   output logic      tdi
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // one test clock: 4 clk low then 4 high; tdo read just before the rise
   // tck stands still low between calls, so no stray edges during bus work
   task automatic tick(input logic m, input logic d, output logic o);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clk);
      o = tdo;
      tck <= 1'b1;
      repeat (4) @(posedge clk);
      tck <= 1'b0;
   endtask
endmodule

// file: tb/bsdr_top_tb_top.sv
// ************************************************************
// scan and bus sequences
// ************************************************************
module bsdr_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import bsdr_pkg::*;
   localparam logic [31:0] PAT = 32'h0000_2b5d; // boundary preload pattern
   logic clk = 0, arst_n = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, d, exp;
   logic [1:0] htrans = 0, in_pad = 0, in_core;
   logic [2:0] hsize = 3'h2;
   logic [3:0] io_pad_in = 0, io_pad_out, io_pad_oe, core_out = 0, core_oe = 0, core_in, po, pe;
   logic tck, tms, tdi, tdo, tdo_oe, user_tdi, b;
   logic user_a_select, user_b_select, user_a_shift_clock, user_b_shift_clock;
   logic user_a_return_data = 1, user_b_return_data = 0;
   logic tap_reset_state, tap_shift_state, tap_update_state;
   logic [4:0] irc;
   int fails = 0, compares = 0, cyc = 0;
   assign hready = hreadyout;
   bsdr_top bsdr_top_i (.*);
   bsdr_scan_host bsdr_scan_host_i (.clk, .tdo, .tck, .tms, .tdi);
   initial begin
      forever #12.5 clk = ~clk;
   end
   task give_verdict;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // hang guard: far above the few thousand cycles the sequence needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         give_verdict;
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (e !== g) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // single word transfer; waits on hready, data taken at data-phase edge
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // from idle: load instruction, shift n data bits lsb first, back to idle
   task automatic scan(input logic [4:0] ir, input int n, input logic [31:0] din);
      logic o;
      d = '0;
      for (int k = 0; k < 4; k++) bsdr_scan_host_i.tick(k < 2, 1'b1, o);
      for (int i = 0; i < 5; i++) bsdr_scan_host_i.tick(i == 4, ir[i], irc[i]);
      for (int k = 0; k < 4; k++) bsdr_scan_host_i.tick(k < 2, 1'b1, o);
      for (int i = 1; i < n; i++) bsdr_scan_host_i.tick(1'b0, din[i - 1], d[i - 1]);
      bsdr_scan_host_i.tick(1'b1, din[n - 1], d[n - 1]);
      bsdr_scan_host_i.tick(1'b1, 1'b1, o);
      bsdr_scan_host_i.tick(1'b0, 1'b1, o);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      bsdr_scan_host_i.tick(1'b0, 1'b1, b);
      scan(INSTR_IDCODE, 32, '1);
      chk("idcode", {ID_REVISION, ID_FAMILY, ID_SIZE, ID_MAKER, ID_LSB}, d);
      chk("ir capture", {27'h0, 3'h0, IR_CAPTURE_LOW}, {27'h0, irc});
      scan(INSTR_BYPASS, 3, 32'h6);
      chk("bypass", 32'h4, d);
      scan(INSTR_USER_A, 2, 32'h3);
      chk("early user", {30'h0, 2'h2}, {d[31:1], user_a_select});
      ahb(1'b1, OFS_USERCODE, 32'h5a3c_0f96);
      ahb(1'b1, OFS_CTRL, 32'h1);
      scan(INSTR_USERCODE, 32, 32'h0);
      chk("usercode", 32'h5a3c_0f96, d);
      chk("ir capture done", {27'h0, 3'h1, IR_CAPTURE_LOW}, {27'h0, irc});
      scan(INSTR_USER_A, 4, '1);
      chk("user a", 32'h1f, {d[30:0], user_a_select});
      scan(INSTR_USER_B, 4, '1);
      chk("user b", 32'h1, {d[29:0], user_a_select, user_b_select});
      core_out <= 4'ha;
      core_oe <= 4'h5;
      io_pad_in <= 4'h6;
      in_pad <= 2'h1;
      scan(INSTR_SAMPLE, 14, PAT);
      exp = {18'h0, in_pad, 12'h0};
      for (int i = 0; i < 4; i++) {exp[3*i+2], exp[3*i+1], exp[3*i], po[i], pe[i]} =
         {io_pad_in[i], core_out[i], core_oe[i], PAT[3*i+1], PAT[3*i]};
      chk("boundary", exp, d);
      scan(INSTR_EXTEST, 14, PAT);
      chk("pads", {24'h0, po, pe}, {24'h0, io_pad_out, io_pad_oe});
      scan(INSTR_INTEST, 14, PAT);
      exp = {18'h0, core_out, core_oe, PAT[13:12], PAT[11], PAT[8], PAT[5], PAT[2]};
      chk("intest", exp, {18'h0, io_pad_out, io_pad_oe, in_core, core_in});
      scan(INSTR_CFG_IN, 32, 32'h1357_9bdf);
      ahb(1'b0, OFS_CFG_WORD, 32'h0);
      chk("cfg word", 32'h1357_9bdf, rd);
      ahb(1'b0, OFS_CFG_COUNT, 32'h0);
      chk("cfg count", 32'h1, rd);
      ahb(1'b1, OFS_READBACK, 32'h2468_ace1);
      scan(INSTR_CFG_OUT, 32, 32'h0);
      chk("readback", 32'h2468_ace1, d);
      ahb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, rd);
      give_verdict;
   end
endmodule
